// *** rtl/ptp_filter_pkg.sv ***
// Purpose: shared constants and carriers of the PTP message filter
// Assumes: 16-bit register words at even byte addresses
// Notes: message type codes follow the PTP header messageType field
package ptp_filter_pkg;
    // ==========================================================
    // register map
    localparam logic [15:0] CFG_ADDR = 16'h0516;
    localparam logic [15:0] DOM_ADDR = 16'h0518;
    localparam logic [15:0] CFG_RESET = 16'h1004;
    localparam logic [15:0] CFG_RW_MASK = 16'h1fff;
    localparam logic [15:0] DOM_RESET = 16'h0200;
    localparam logic [15:0] DOM_RW_MASK = 16'h0fff;
    localparam int UNICAST_BIT = 12;
    localparam int ALT_MASTER_BIT = 11;
    localparam int ALL_TOP_QUEUE_BIT = 10;
    localparam int PAIR_SYNC_BIT = 9;
    localparam int PAIR_DELAY_BIT = 8;
    localparam int PAIR_PDELAY_BIT = 7;
    localparam int NO_MASTER_DROP_BIT = 5;
    localparam int DOMAIN_CHECK_BIT = 4;
    localparam int EGRESS_CKSUM_BIT = 2;
    localparam int DOMAIN_LSB = 0;
    localparam int DOMAIN_W = 8;
    // ==========================================================
    // protocol constants
    localparam logic [15:0] PTP_EVENT_PORT = 16'h013f;
    localparam logic [15:0] PTP_GENERAL_PORT = 16'h0140;
    localparam logic [3:0] MT_SYNC = 4'h0;
    localparam logic [3:0] MT_DELAY_REQ = 4'h1;
    localparam logic [3:0] MT_PDELAY_REQ = 4'h2;
    localparam logic [3:0] MT_PDELAY_RESP = 4'h3;
    localparam logic [3:0] MT_FOLLOW_UP = 4'h8;
    localparam logic [3:0] MT_DELAY_RESP = 4'h9;
    localparam logic [3:0] MT_PDELAY_FU = 4'ha;
    localparam int SRC_PORT_W = 80;

    typedef enum logic [1:0] {
        CK_KEEP = 2'h0,
        CK_RECOMPUTE = 2'h1,
        CK_ZERO = 2'h2
    } cksum_mode_t;

    // parsed header of one frame, offered for one cycle
    typedef struct packed {
        logic [3:0] msg_type;
        logic [7:0] domain;
        logic [15:0] seq_id;
        logic [SRC_PORT_W-1:0] src_port;
        logic reserved_addr;
        logic is_udp;
        logic is_ipv6;
        logic [15:0] udp_dport;
        logic from_host_port;
        logic from_active_master;
        logic cksum_zero;
        logic modified;
    } msg_info_t;

    typedef struct packed {
        logic is_ptp;
        logic use_lookup;
        logic to_host;
        logic to_nonhost;
        logic drop;
        logic top_queue;
        cksum_mode_t cksum;
    } verdict_t;
endpackage : ptp_filter_pkg

// *** rtl/ptp_message_filter_forward_ctrl.sv ***
// Purpose: classify PTP frames and decide forwarding, queue and checksum
// Assumes: header fields already parsed; register port on the core clock
// Notes: one verdict per offered frame, one cycle later
// Functional notes
// - unicast enable lets unicast PTP be recognized
// - port 319/320, non-reserved address: lookup-forwarded unicast
// - unicast disabled: only multicast PTP recognized
// - alternate master: same-domain master Sync/Delay_Req also to host
// - no alternate master: drop those toward host
// - queue bit: all or only event to top
// - Follow_Up reaches host only on Sync match
// - Delay_Resp reaches host only on Delay_Req match
// - Pdelay responses reach host only on match
// - drop Sync/Follow_Up/Delay_Req without best master
// - domain check: match to host, else drop
// - checksum bit set: recompute on modified frames
// - checksum bit clear: write zero checksum
// - zero IPv4 checksum stays zero
// - IPv6 UDP checksum always updated
// - expected domain is domain register bits 7:0
`timescale 1ns/1ps
module ptp_message_filter_forward_ctrl
    import ptp_filter_pkg::*;
#(
    parameter int PAIR_DEPTH = 8
) (
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic [15:0] REG_ADDR_I,
    input wire logic [15:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [15:0] REG_RDATA_O,
    input wire logic MSG_VALID_I,
    input wire msg_info_t MSG_I,
    input wire logic BEST_MASTER_SELECTION_I,
    output logic VERDICT_VALID_O,
    output verdict_t VERDICT_O
);
    localparam int PTR_W = (PAIR_DEPTH > 1) ? $clog2(PAIR_DEPTH) : 1;

    typedef struct packed {
        logic valid;
        logic [1:0] kind;
        logic [7:0] domain;
        logic [15:0] seq_id;
        logic [SRC_PORT_W-1:0] src_port;
    } pair_entry_t;

    // ==========================================================
    // configuration registers
    logic [15:0] cfg;
    logic [15:0] dom;
    logic [15:0] next_cfg;
    logic [15:0] next_dom;
    logic [15:0] next_rdata;

    always_comb begin
        next_cfg = cfg;
        next_dom = dom;
        next_rdata = REG_RDATA_O;
        if (REG_WR_I && REG_ADDR_I == CFG_ADDR) begin
            next_cfg = REG_WDATA_I & CFG_RW_MASK;
        end
        if (REG_WR_I && REG_ADDR_I == DOM_ADDR) begin
            next_dom = REG_WDATA_I & DOM_RW_MASK;
        end
        if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                CFG_ADDR: next_rdata = cfg;
                DOM_ADDR: next_rdata = dom;
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cfg <= CFG_RESET;
            dom <= DOM_RESET;
            REG_RDATA_O <= 16'h0000;
        end else begin
            cfg <= next_cfg;
            dom <= next_dom;
            REG_RDATA_O <= next_rdata;
        end
    end

    logic [DOMAIN_W-1:0] expected_domain_number;
    assign expected_domain_number = dom[DOMAIN_LSB +: DOMAIN_W];

    // ==========================================================
    // request table for pairing responses with requests
    // kind: 0 sync, 1 delay_req, 2 pdelay_req, 3 none
    function automatic logic [1:0] req_kind(input logic [3:0] mt);
        unique case (mt)
            MT_SYNC, MT_FOLLOW_UP: req_kind = 2'h0;
            MT_DELAY_REQ, MT_DELAY_RESP: req_kind = 2'h1;
            MT_PDELAY_REQ, MT_PDELAY_RESP, MT_PDELAY_FU: req_kind = 2'h2;
            default: req_kind = 2'h3;
        endcase
    endfunction : req_kind

    pair_entry_t table_q [PAIR_DEPTH];
    pair_entry_t next_table [PAIR_DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] next_wr_ptr;
    logic [PAIR_DEPTH-1:0] hit;
    logic is_req;
    logic is_resp;
    pair_entry_t probe;

    assign is_req = (MSG_I.msg_type == MT_SYNC) || (MSG_I.msg_type == MT_DELAY_REQ)
        || (MSG_I.msg_type == MT_PDELAY_REQ);
    assign is_resp = (MSG_I.msg_type == MT_FOLLOW_UP) || (MSG_I.msg_type == MT_DELAY_RESP)
        || (MSG_I.msg_type == MT_PDELAY_RESP) || (MSG_I.msg_type == MT_PDELAY_FU);
    assign probe = '{valid: 1'b1, kind: req_kind(MSG_I.msg_type), domain: MSG_I.domain,
        seq_id: MSG_I.seq_id, src_port: MSG_I.src_port};

    genvar gi;
    generate
        for (gi = 0; gi < PAIR_DEPTH; gi++) begin : g_hit
            assign hit[gi] = (table_q[gi] == probe);
        end
    endgenerate

    // ==========================================================
    // classification
    logic is_ptp;
    logic is_unicast;
    logic sync_or_dreq;
    logic pair_on;
    logic next_vvalid;
    verdict_t next_verdict;

    always_comb begin
        next_table = table_q;
        next_wr_ptr = wr_ptr;
        if (MSG_VALID_I && is_ptp && is_req) begin
            next_table[wr_ptr] = probe;
            next_wr_ptr = (wr_ptr == PTR_W'(PAIR_DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
        end
    end

    always_comb begin
        is_unicast = cfg[UNICAST_BIT] && MSG_I.is_udp && !MSG_I.reserved_addr
            && (MSG_I.udp_dport == PTP_EVENT_PORT
            || MSG_I.udp_dport == PTP_GENERAL_PORT);
        is_ptp = MSG_I.reserved_addr || is_unicast;
        sync_or_dreq = (MSG_I.msg_type == MT_SYNC) || (MSG_I.msg_type == MT_DELAY_REQ);
        unique case (req_kind(MSG_I.msg_type))
            2'h0: pair_on = cfg[PAIR_SYNC_BIT];
            2'h1: pair_on = cfg[PAIR_DELAY_BIT];
            2'h2: pair_on = cfg[PAIR_PDELAY_BIT];
            default: pair_on = 1'b0;
        endcase

        next_vvalid = MSG_VALID_I;
        next_verdict = '{is_ptp: is_ptp, use_lookup: is_unicast, to_host: 1'b0,
            to_nonhost: 1'b1, drop: 1'b0, top_queue: 1'b0, cksum: CK_KEEP};
        if (is_ptp) begin
            next_verdict.to_host = !MSG_I.from_host_port;
            next_verdict.top_queue = cfg[ALL_TOP_QUEUE_BIT]
                || !MSG_I.msg_type[3];
            // the active master must not see its own domain's timing echoed to the host
            if (sync_or_dreq && !MSG_I.from_host_port && MSG_I.from_active_master
                && MSG_I.domain == expected_domain_number
                && !cfg[ALT_MASTER_BIT]) begin
                next_verdict.to_host = 1'b0;
            end
            // non-host forwarding stays set for alternate masters
            if (is_resp && pair_on) begin
                next_verdict.to_host = next_verdict.to_host && (|hit);
            end
            if (cfg[DOMAIN_CHECK_BIT]) begin
                if (MSG_I.domain != expected_domain_number) begin
                    next_verdict.drop = 1'b1;
                end
            end
            if (cfg[NO_MASTER_DROP_BIT] && !BEST_MASTER_SELECTION_I
                && (sync_or_dreq || MSG_I.msg_type == MT_FOLLOW_UP)) begin
                next_verdict.drop = 1'b1;
            end
            if (next_verdict.drop) begin
                next_verdict.to_host = 1'b0;
                next_verdict.to_nonhost = 1'b0;
            end
        end
        if (MSG_I.is_udp && MSG_I.modified) begin
            if (MSG_I.is_ipv6) begin
                next_verdict.cksum = CK_RECOMPUTE;
            end else if (MSG_I.cksum_zero) begin
                next_verdict.cksum = CK_ZERO;
            end else if (cfg[EGRESS_CKSUM_BIT]) begin
                next_verdict.cksum = CK_RECOMPUTE;
            end else begin
                next_verdict.cksum = CK_ZERO;
            end
        end
        // idle cycles must not disturb the last verdict, it stands until the next frame
        if (!MSG_VALID_I) begin
            next_verdict = VERDICT_O;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            for (int i = 0; i < PAIR_DEPTH; i++) begin
                table_q[i] <= '0;
            end
            wr_ptr <= '0;
            VERDICT_VALID_O <= 1'b0;
            VERDICT_O <= '0;
        end else begin
            table_q <= next_table;
            wr_ptr <= next_wr_ptr;
            VERDICT_VALID_O <= next_vvalid;
            VERDICT_O <= next_verdict;
        end
    end

    // ==========================================================
    // checks
    unicast_recog_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        MSG_VALID_I && cfg[UNICAST_BIT] && MSG_I.is_udp && !MSG_I.reserved_addr
        && MSG_I.udp_dport == PTP_EVENT_PORT |=> VERDICT_O.is_ptp && VERDICT_O.use_lookup)
        else $error("unicast ptp frame not recognized");
    multicast_only_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        MSG_VALID_I && !cfg[UNICAST_BIT] && !MSG_I.reserved_addr |=> !VERDICT_O.is_ptp)
        else $error("unicast frame recognized while disabled");
    alt_master_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        MSG_VALID_I && is_ptp && sync_or_dreq && MSG_I.from_active_master
        && !MSG_I.from_host_port && MSG_I.domain == expected_domain_number
        && !cfg[ALT_MASTER_BIT] |=> !VERDICT_O.to_host)
        else $error("master frame reached host without alternate master");
    top_queue_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        MSG_VALID_I && is_ptp && !cfg[ALL_TOP_QUEUE_BIT] && MSG_I.msg_type[3]
        |=> !VERDICT_O.top_queue)
        else $error("general message placed on top queue");
    pair_sync_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        MSG_VALID_I && is_ptp && cfg[PAIR_SYNC_BIT] && MSG_I.msg_type == MT_FOLLOW_UP
        && hit == '0 |=> !VERDICT_O.to_host)
        else $error("unpaired follow_up reached host");
    no_master_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        MSG_VALID_I && is_ptp && cfg[NO_MASTER_DROP_BIT] && !BEST_MASTER_SELECTION_I
        && MSG_I.msg_type == MT_SYNC |=> VERDICT_O.drop && !VERDICT_O.to_nonhost)
        else $error("sync kept without best master");
    domain_chk_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        MSG_VALID_I && is_ptp && cfg[DOMAIN_CHECK_BIT]
        && MSG_I.domain != expected_domain_number |=> VERDICT_O.drop)
        else $error("domain mismatch not dropped");
    cksum_zero_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        MSG_VALID_I && MSG_I.is_udp && MSG_I.modified && !MSG_I.is_ipv6
        && !cfg[EGRESS_CKSUM_BIT] |=> VERDICT_O.cksum == CK_ZERO)
        else $error("checksum not zeroed");
    ipv6_cksum_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        MSG_VALID_I && MSG_I.is_udp && MSG_I.modified && MSG_I.is_ipv6
        |=> VERDICT_O.cksum == CK_RECOMPUTE)
        else $error("ipv6 checksum not updated");
    keep_zero_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        MSG_VALID_I && MSG_I.is_udp && !MSG_I.is_ipv6 && MSG_I.cksum_zero
        |=> VERDICT_O.cksum != CK_RECOMPUTE)
        else $error("zero checksum recomputed");
endmodule : ptp_message_filter_forward_ctrl

// *** verification/ptp_frame_source.sv ***
// Purpose: far-side model offering parsed PTP headers to the filter
// Assumes: one header per call, launched just after a rising edge
// Notes: released header lines show the inverse of the last frame, never a stale copy
`timescale 1ns/1ps
module ptp_frame_source
    import ptp_filter_pkg::*;
(
    input wire logic clk_i,
    output logic valid_o,
    output msg_info_t msg_o
);
    // ==========================================================
    // frame offer
    initial begin
        valid_o = 1'b0;
        msg_o = '0;
    end

    task automatic send(input msg_info_t m);
        @(posedge clk_i);
        #1;
        valid_o = 1'b1;
        msg_o = m;
        @(posedge clk_i);
        #1;
        valid_o = 1'b0;
        // inverse pattern so a filter that samples late cannot see a valid header
        msg_o = ~m;
    endtask : send
endmodule : ptp_frame_source

// *** verification/testbench.sv ***
// Purpose: directed checks of PTP classification, forwarding and checksum verdicts
// Assumes: strobed register port, one verdict one cycle after each offered header
// Notes: expectations come from the bit meanings of the configuration word
`timescale 1ns/1ps
module testbench
    import ptp_filter_pkg::*;
;
    logic CLK_I;
    logic ARST_N_I;
    logic [15:0] REG_ADDR_I;
    logic [15:0] REG_WDATA_I;
    logic REG_WR_I;
    logic REG_RD_I;
    logic [15:0] REG_RDATA_O;
    logic MSG_VALID_I;
    msg_info_t MSG_I;
    logic BEST_MASTER_SELECTION_I;
    logic VERDICT_VALID_O;
    verdict_t VERDICT_O;
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    verdict_t v;
    msg_info_t m;
    logic [3:0] req_t [4] = '{MT_SYNC, MT_DELAY_REQ, MT_PDELAY_REQ, MT_PDELAY_REQ};
    logic [3:0] rsp_t [4] = '{MT_FOLLOW_UP, MT_DELAY_RESP, MT_PDELAY_RESP, MT_PDELAY_FU};
    logic [3:0] all_t [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha};

    ptp_message_filter_forward_ctrl u_ptp_message_filter_forward_ctrl (.CLK_I(CLK_I),
        .ARST_N_I(ARST_N_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
        .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
        .MSG_VALID_I(MSG_VALID_I), .MSG_I(MSG_I),
        .BEST_MASTER_SELECTION_I(BEST_MASTER_SELECTION_I),
        .VERDICT_VALID_O(VERDICT_VALID_O), .VERDICT_O(VERDICT_O));
    ptp_frame_source u_ptp_frame_source (.clk_i(CLK_I), .valid_o(MSG_VALID_I), .msg_o(MSG_I));

    // ==========================================================
    // clock, timeout and shared tasks
    initial begin
        CLK_I = 1'b0;
        forever #2.5 CLK_I = ~CLK_I;
    end

    task automatic give_verdict();
        if (err_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict

    // about 150 cycles are needed; the margin covers a stuck handshake only
    always @(posedge CLK_I) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            $display("mismatch at %0t: run did not finish", $time);
            give_verdict();
        end
    end

    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge CLK_I);
        #1;
        REG_WR_I = 1'b1;
        REG_ADDR_I = a;
        REG_WDATA_I = d;
        @(posedge CLK_I);
        #1;
        REG_WR_I = 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge CLK_I);
        #1;
        REG_RD_I = 1'b1;
        REG_ADDR_I = a;
        @(posedge CLK_I);
        #1;
        REG_RD_I = 1'b0;
        chk(REG_RDATA_O === exp, "register read value");
    endtask : reg_rd

    function automatic msg_info_t mk(input logic [3:0] t, input logic [7:0] d,
                                     input logic [15:0] s);
        mk = '0;
        mk.msg_type = t;
        mk.domain = d;
        mk.seq_id = s;
        mk.src_port = 80'h1;
        mk.reserved_addr = 1'b1;
        mk.is_udp = 1'b1;
        mk.udp_dport = 16'h013f;
    endfunction : mk

    task automatic frame(input msg_info_t f);
        u_ptp_frame_source.send(f);
        chk(VERDICT_VALID_O === 1'b1, "verdict pulse missing");
        v = VERDICT_O;
    endtask : frame

    // ==========================================================
    // main sequence
    initial begin
        ARST_N_I = 1'b0;
        REG_ADDR_I = 16'h0000;
        REG_WDATA_I = 16'h0000;
        REG_WR_I = 1'b0;
        REG_RD_I = 1'b0;
        BEST_MASTER_SELECTION_I = 1'b1;
        repeat (2) @(posedge CLK_I);
        #1;
        ARST_N_I = 1'b1;
        reg_rd(16'h0516, 16'h1004);
        reg_rd(16'h0518, 16'h0200);
        reg_rd(16'h0600, 16'h0000);
        reg_wr(16'h0516, 16'h1ff7);
        reg_rd(16'h0516, 16'h1ff7);
        reg_wr(16'h0516, 16'h1004);
        m = mk(MT_SYNC, 8'h00, 16'h0001);
        m.reserved_addr = 1'b0;
        frame(m);
        chk(v.is_ptp === 1'b1 && v.use_lookup === 1'b1, "unicast 319");
        m.udp_dport = 16'h0140;
        frame(m);
        chk(v.is_ptp === 1'b1 && v.use_lookup === 1'b1, "unicast 320");
        m.udp_dport = 16'h0141;
        frame(m);
        chk(v.is_ptp === 1'b0, "port 321 taken as ptp");
        reg_wr(16'h0516, 16'h0004);
        m.udp_dport = 16'h013f;
        frame(m);
        chk(v.is_ptp === 1'b0, "unicast seen while disabled");
        frame(mk(MT_SYNC, 8'h00, 16'h0001));
        chk(v.is_ptp === 1'b1, "multicast lost");
        for (int q = 0; q < 2; q++) begin
            reg_wr(16'h0516, q ? 16'h1404 : 16'h1004);
            for (int i = 0; i < 7; i++) begin
                frame(mk(all_t[i], 8'h00, 16'h0002));
                chk(v.top_queue === (q == 1 || i < 4), "queue choice");
            end
        end
        for (int a = 0; a < 2; a++) begin
            reg_wr(16'h0516, a ? 16'h1804 : 16'h1004);
            for (int i = 0; i < 2; i++) begin
                m = mk(req_t[i], 8'h00, 16'h0003);
                m.from_active_master = 1'b1;
                frame(m);
                chk(v.to_nonhost === 1'b1, "master frame not to ports");
                chk(v.to_host === (a == 1), "master frame host forwarding");
                m.domain = 8'h05;
                frame(m);
                chk(v.to_nonhost === 1'b1, "other domain not forwarded");
            end
        end
        reg_wr(16'h0516, 16'h1384);
        for (int i = 0; i < 4; i++) begin
            frame(mk(req_t[i], 8'h00, 16'(i + 10)));
            frame(mk(rsp_t[i], 8'h00, 16'(i + 10)));
            chk(v.to_host === 1'b1, "paired response not to host");
            frame(mk(rsp_t[i], 8'h00, 16'(i + 40)));
            chk(v.to_host === 1'b0, "unpaired sequence to host");
            m = mk(rsp_t[i], 8'h00, 16'(i + 10));
            m.src_port = 80'h2;
            frame(m);
            chk(v.to_host === 1'b0, "unpaired source to host");
        end
        reg_wr(16'h0516, 16'h1024);
        for (int b = 0; b < 2; b++) begin
            BEST_MASTER_SELECTION_I = b[0];
            for (int i = 0; i < 3; i++) begin
                frame(mk(i == 2 ? MT_FOLLOW_UP : req_t[i], 8'h00, 16'h0004));
                chk(v.drop === (b == 0), "drop without best master");
            end
        end
        reg_wr(16'h0518, 16'h0207);
        reg_rd(16'h0518, 16'h0207);
        reg_wr(16'h0516, 16'h1014);
        frame(mk(MT_SYNC, 8'h07, 16'h0005));
        chk(v.to_host === 1'b1 && v.drop === 1'b0, "matching domain");
        frame(mk(MT_SYNC, 8'h03, 16'h0005));
        chk(v.to_host === 1'b0 && v.to_nonhost === 1'b0, "foreign domain kept");
        for (int c = 0; c < 2; c++) begin
            reg_wr(16'h0516, c ? 16'h1000 : 16'h1004);
            m = mk(MT_FOLLOW_UP, 8'h00, 16'h0006);
            m.modified = 1'b1;
            frame(m);
            chk(v.cksum === (c ? CK_ZERO : CK_RECOMPUTE), "ipv4 checksum");
            m.cksum_zero = 1'b1;
            frame(m);
            chk(v.cksum !== CK_RECOMPUTE, "zero checksum rewritten");
            m.cksum_zero = 1'b0;
            m.is_ipv6 = 1'b1;
            frame(m);
            chk(v.cksum === CK_RECOMPUTE, "ipv6 checksum");
        end
        @(posedge CLK_I);
        #1;
        chk(VERDICT_O === v && VERDICT_VALID_O === 1'b0, "verdict did not stand");
        give_verdict();
    end
endmodule : testbench
